//--- design/rps_cfg.svh
/*
  Constants of the receive PCS status block: register offsets, field positions, reset values and timing counts.
  Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

`define RPS_CLK_NS        40
`define RPS_BER_WIN_NS    125000
`define RPS_BER_WIN_CYC   (`RPS_BER_WIN_NS / `RPS_CLK_NS)
`define RPS_BER_LIMIT     5'h10
`define RPS_LOCK_GOOD     7'h40
`define RPS_LOCK_WIN      7'h40
`define RPS_LOCK_BAD      5'h10
`define RPS_CC_PPM        200
`define RPS_CC_DEPTH      5'h10
`define RPS_CC_MID        5'h08

`define RPS_OFF_CTRL      8'h00
`define RPS_OFF_STATUS    8'h04
`define RPS_OFF_INT_STAT  8'h08
`define RPS_OFF_INT_EN    8'h0C
`define RPS_OFF_INT_CLR   8'h10
`define RPS_OFF_ERR_CNT   8'h14
`define RPS_OFF_BAD_CNT   8'h18

`define RPS_CTRL_TEST     0
`define RPS_CTRL_CCRST    1
`define RPS_CTRL_RST      32'h0000_0000
`define RPS_INT_EN_RST    6'h00

`define RPS_EV_FIFO       0
`define RPS_EV_FAULT      1
`define RPS_EV_BER        2
`define RPS_EV_UNLOCK     3
`define RPS_EV_MISMATCH   4
`define RPS_EV_BADCODE    5
`define RPS_EV_W          6

`endif

//--- design/rps_pkg.sv
/*
  Types and block-type decoding shared by the receive PCS status block.
  Assumes blocks arrive as a two-bit sync header and an eight-bit block type field.
*/
package rps_pkg;

  typedef enum logic [1:0] {
    RPS_SH_DATA = 2'h1,
    RPS_SH_CTRL = 2'h2
  } rps_sh_e;

  typedef enum logic {
    RPS_DEC_INIT,
    RPS_DEC_RUN
  } rps_dec_e;

  typedef enum logic [1:0] {
    RPS_K_OTHER,
    RPS_K_START,
    RPS_K_TERM,
    RPS_K_BAD
  } rps_kind_e;

  // Classifies one block by its header and type field.
  function automatic rps_kind_e rps_kind(input logic [1:0] sh, input logic [7:0] bt);
    rps_kind_e k;
    k = RPS_K_BAD;
    if (sh == RPS_SH_DATA) begin
      k = RPS_K_OTHER;
    end else if (sh == RPS_SH_CTRL) begin
      case (bt)
        8'h1E, 8'h2D, 8'h4B, 8'h55: k = RPS_K_OTHER;
        8'h33, 8'h66, 8'h78:        k = RPS_K_START;
        8'h87, 8'h99, 8'hAA, 8'hB4, 8'hCC, 8'hD2, 8'hE1, 8'hFF: k = RPS_K_TERM;
        default:                    k = RPS_K_BAD;
      endcase
    end
    return k;
  endfunction

endpackage

//--- design/rps_ccomp.sv
/*
  Occupancy tracker of the receive clock compensation buffer; pulses an error on underflow or overflow.
  Assumes write and read strobes come from the recovered and local sides, already on pclk.
*/
`timescale 1ns/1ps
`include "rps_cfg.svh"

module rps_ccomp (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Buffer activity.
  input  wire logic clr,
  input  wire logic wr_en,
  input  wire logic rd_en,
  // Result.
  output logic      err_pulse
);

  logic [4:0] fill_r;
  logic [4:0] fill_nxt;
  wire        full  = (fill_r == `RPS_CC_DEPTH);
  wire        empty = (fill_r == 5'h00);
  wire        ovf   = wr_en && !rd_en && full;
  wire        unf   = rd_en && !wr_en && empty;

  // The buffer starts half full so that it can take up drift in either direction.
  always_comb begin
    fill_nxt = fill_r;
    if (clr) begin
      fill_nxt = `RPS_CC_MID;
    end else if (wr_en && !rd_en && !full) begin
      fill_nxt = fill_r + 5'h01;
    end else if (rd_en && !wr_en && !empty) begin
      fill_nxt = fill_r - 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_r    <= `RPS_CC_MID;
      err_pulse <= 1'b0;
    end else if (ce) begin
      fill_r    <= fill_nxt;
      err_pulse <= !clr && (ovf || unf);
    end
  end

endmodule

//--- design/rps_blkchk.sv
/*
  Checks the two blocks received per cycle for invalid types, illegal order and test-pattern mismatch.
  Assumes blk_vld marks cycles in which both block slots are valid.
*/
`timescale 1ns/1ps
`include "rps_cfg.svh"

module rps_blkchk (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // Received blocks.
  input  wire logic       blk_vld,
  input  wire logic [1:0] sh0,
  input  wire logic [7:0] bt0,
  input  wire logic [1:0] sh1,
  input  wire logic [7:0] bt1,
  // Test-pattern mode.
  input  wire logic       test_en,
  // Increments.
  output logic [1:0]      bad_inc,
  output logic            bad_vld,
  output logic [1:0]      mis_inc,
  output logic            mis_vld
);

  rps_pkg::rps_kind_e k0;
  rps_pkg::rps_kind_e k1;
  logic               in_frame_r;
  logic               mid_frame;
  logic               end_frame;
  logic               seq0;
  logic               seq1;

  assign k0 = rps_pkg::rps_kind(sh0, bt0);
  assign k1 = rps_pkg::rps_kind(sh1, bt1);

  // A start inside a frame or a terminate outside one is out of order.
  assign seq0      = (k0 == rps_pkg::RPS_K_START) ? in_frame_r :
                     (k0 == rps_pkg::RPS_K_TERM) ? !in_frame_r : 1'b0;
  assign mid_frame = (k0 == rps_pkg::RPS_K_START) ? 1'b1 :
                     (k0 == rps_pkg::RPS_K_TERM || k0 == rps_pkg::RPS_K_BAD) ? 1'b0 : in_frame_r;
  assign seq1      = (k1 == rps_pkg::RPS_K_START) ? mid_frame :
                     (k1 == rps_pkg::RPS_K_TERM) ? !mid_frame : 1'b0;
  assign end_frame = (k1 == rps_pkg::RPS_K_START) ? 1'b1 :
                     (k1 == rps_pkg::RPS_K_TERM || k1 == rps_pkg::RPS_K_BAD) ? 1'b0 : mid_frame;

  wire b0 = (k0 == rps_pkg::RPS_K_BAD) || seq0;
  wire b1 = (k1 == rps_pkg::RPS_K_BAD) || seq1;
  // Only the idle control type is compared; payload bits are not checked.
  wire m0 = !(sh0 == rps_pkg::RPS_SH_CTRL && bt0 == 8'h1E);
  wire m1 = !(sh1 == rps_pkg::RPS_SH_CTRL && bt1 == 8'h1E);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_r <= 1'b0;
      bad_inc    <= 2'h0;
      bad_vld    <= 1'b0;
      mis_inc    <= 2'h0;
      mis_vld    <= 1'b0;
    end else if (ce) begin
      in_frame_r <= blk_vld ? end_frame : in_frame_r;
      bad_vld    <= blk_vld;
      bad_inc    <= blk_vld ? {1'b0, b0} + {1'b0, b1} : 2'h0;
      mis_vld    <= blk_vld && test_en;
      mis_inc    <= (blk_vld && test_en) ? {1'b0, m0} + {1'b0, m1} : 2'h0;
    end
  end

endmodule

//--- design/rps_top.sv
/*
  Receive PCS status and statistics reporting, with an APB register file and a level interrupt.
  Assumes all inputs are synchronous to pclk, the recovered receive clock, and presetn is the receive-side reset.
*/
`timescale 1ns/1ps
`include "rps_cfg.svh"

//Contract
// - Compensation-buffer error flag goes to 1 on buffer underflow or overflow.
// - Buffer absorbs up to 200 ppm offset without an error.
// - Local fault is a level, high while the decoder sits in its init state.
// - Excess error rate flag is a level while the error rate exceeds the threshold.
// - Four lane block-lock bits, each high while that lane holds block lock.
// - Eight-bit mismatch increment counts test-pattern mismatches in that cycle.
// - Mismatch increment is active only while test-pattern enable is 1.
// - Each mismatch increment stands for exactly one cycle.
// - Mismatch valid strobe marks meaningful increments; consumer accumulates only then.
// - Two-bit code-violation increment counts blocks with invalid type or content; the code checks only the sync header and block type field.
// - Blocks arriving in illegal order also count as code violations.
// - Code-violation valid strobe marks meaningful increments; consumer samples only then.
module rps_top (
  // Clock, reset and enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive datapath.
  input  wire logic        cc_wr_en,
  input  wire logic        cc_rd_en,
  input  wire logic [3:0]  lane_hdr_vld,
  input  wire logic [3:0]  lane_hdr_ok,
  input  wire logic        blk_vld,
  input  wire logic [1:0]  blk_sh0,
  input  wire logic [7:0]  blk_type0,
  input  wire logic [1:0]  blk_sh1,
  input  wire logic [7:0]  blk_type1,
  // Status and statistics.
  output logic             rx_fifo_err,
  output logic             rx_local_fault,
  output logic             rx_excess_error_rate_flag,
  output logic [3:0]       rx_block_lock,
  output logic [7:0]       rx_test_err,
  output logic             rx_test_err_valid,
  output logic [1:0]       rx_bad_code,
  output logic             rx_bad_code_valid,
  // Interrupt.
  output logic             irq
);

  function automatic logic [2:0] pop4(input logic [3:0] v);
    return {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction

  localparam logic [11:0] BER_WIN = 12'(`RPS_BER_WIN_CYC);

  logic [31:0]           ctrl_r;
  logic [`RPS_EV_W-1:0]  int_stat_r;
  logic [`RPS_EV_W-1:0]  int_en_r;
  logic [31:0]           err_cnt_r;
  logic [31:0]           bad_cnt_r;
  logic                  cc_pulse;
  logic [1:0]            bad_inc;
  logic                  bad_vld;
  logic [1:0]            mis_inc;
  logic                  mis_vld;
  logic [6:0]            good_r  [4];
  logic [6:0]            win_r   [4];
  logic [4:0]            badh_r  [4];
  logic [11:0]           ber_tmr_r;
  logic [4:0]            ber_cnt_r;
  rps_pkg::rps_dec_e     dec_r;
  rps_pkg::rps_dec_e     dec_nxt;

  // APB decode.
  wire        setup    = psel && !penable && !pready;
  wire        wr_take  = psel && penable && pready && pwrite;
  wire        hit_ctrl = (paddr == `RPS_OFF_CTRL);
  wire        hit_sts  = (paddr == `RPS_OFF_STATUS);
  wire        hit_ist  = (paddr == `RPS_OFF_INT_STAT);
  wire        hit_ien  = (paddr == `RPS_OFF_INT_EN);
  wire        hit_icl  = (paddr == `RPS_OFF_INT_CLR);
  wire        hit_ecnt = (paddr == `RPS_OFF_ERR_CNT);
  wire        hit_bcnt = (paddr == `RPS_OFF_BAD_CNT);
  wire        mapped   = hit_ctrl | hit_sts | hit_ist | hit_ien | hit_icl | hit_ecnt | hit_bcnt;
  wire [31:0] status_w = {22'h0, rx_bad_code_valid, rx_test_err_valid, rx_block_lock,
                          rx_excess_error_rate_flag, rx_local_fault, rx_fifo_err, dec_r == rps_pkg::RPS_DEC_RUN};
  wire [31:0] rdata_w  = hit_ctrl ? ctrl_r :
                         hit_sts  ? status_w :
                         hit_ist  ? {26'h0, int_stat_r} :
                         hit_ien  ? {26'h0, int_en_r} :
                         hit_ecnt ? err_cnt_r :
                         hit_bcnt ? bad_cnt_r : 32'h0000_0000;
  wire        test_en  = ctrl_r[`RPS_CTRL_TEST];
  wire        cc_clr   = ctrl_r[`RPS_CTRL_CCRST];

  // Lane lock and error rate.
  wire [3:0] hdr_bad   = lane_hdr_vld & ~lane_hdr_ok;
  wire [4:0] ber_sum   = ber_cnt_r + {2'h0, pop4(hdr_bad)};
  wire [4:0] ber_sat   = (ber_sum < ber_cnt_r) ? 5'h1F : ber_sum;
  wire       ber_end   = (ber_tmr_r == BER_WIN - 12'h001);
  wire       all_lock  = &rx_block_lock;
  wire       ber_hi    = ber_sat >= `RPS_BER_LIMIT;
  logic [3:0] lock_nxt;

  // Decoder sequencing: run only with every lane locked and an acceptable error rate.
  always_comb begin
    dec_nxt = dec_r;
    case (dec_r)
      rps_pkg::RPS_DEC_INIT: if (all_lock && !rx_excess_error_rate_flag) dec_nxt = rps_pkg::RPS_DEC_RUN;
      rps_pkg::RPS_DEC_RUN:  if (!all_lock || rx_excess_error_rate_flag) dec_nxt = rps_pkg::RPS_DEC_INIT;
      default:               dec_nxt = rps_pkg::RPS_DEC_INIT;
    endcase
  end

  // Lock needs 64 clean headers in a row; 16 bad ones inside a 64-header window drop it.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!rx_block_lock[i]) begin
        lock_nxt[i] = lane_hdr_vld[i] && lane_hdr_ok[i] && (good_r[i] == `RPS_LOCK_GOOD - 7'h01);
      end else begin
        lock_nxt[i] = !(lane_hdr_vld[i] && !lane_hdr_ok[i] && (badh_r[i] == `RPS_LOCK_BAD - 5'h01));
      end
    end
  end

  // Events that set sticky interrupt status.
  wire [`RPS_EV_W-1:0] ev = {
    bad_vld && (bad_inc != 2'h0),
    mis_vld && (mis_inc != 2'h0),
    |(rx_block_lock & ~lock_nxt),
    ber_end && ber_hi && !rx_excess_error_rate_flag,
    dec_r == rps_pkg::RPS_DEC_RUN && dec_nxt == rps_pkg::RPS_DEC_INIT,
    cc_pulse
  };
  wire [`RPS_EV_W-1:0] clr_w = (wr_take && hit_icl) ? pwdata[`RPS_EV_W-1:0] : '0;

  rps_ccomp u_ccomp (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .clr       (cc_clr),
    .wr_en     (cc_wr_en),
    .rd_en     (cc_rd_en),
    .err_pulse (cc_pulse)
  );

  rps_blkchk u_blkchk (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .blk_vld (blk_vld),
    .sh0     (blk_sh0),
    .bt0     (blk_type0),
    .sh1     (blk_sh1),
    .bt1     (blk_type1),
    .test_en (test_en),
    .bad_inc (bad_inc),
    .bad_vld (bad_vld),
    .mis_inc (mis_inc),
    .mis_vld (mis_vld)
  );

  // APB access: no wait cycle; pready and read data are set in the setup phase, so both leave flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= setup && !pwrite ? rdata_w : 32'h0000_0000;
    end
  end

  // Software registers; the buffer reset bit clears itself after one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= `RPS_CTRL_RST;
      int_en_r   <= `RPS_INT_EN_RST;
      int_stat_r <= '0;
      irq        <= 1'b0;
    end else if (ce) begin
      if (wr_take && hit_ctrl) begin
        ctrl_r <= {30'h0, pwdata[`RPS_CTRL_CCRST], pwdata[`RPS_CTRL_TEST]};
      end else begin
        ctrl_r[`RPS_CTRL_CCRST] <= 1'b0;
      end
      if (wr_take && hit_ien) begin
        int_en_r <= pwdata[`RPS_EV_W-1:0];
      end
      // A new event wins over a clear arriving in the same cycle.
      int_stat_r <= (int_stat_r & ~clr_w) | ev;
      irq        <= |(((int_stat_r & ~clr_w) | ev) & int_en_r);
    end
  end

  // Accumulators for software; they wrap and clear on a write of any value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt_r <= 32'h0000_0000;
      bad_cnt_r <= 32'h0000_0000;
    end else if (ce) begin
      err_cnt_r <= (wr_take && hit_ecnt) ? 32'h0000_0000 : err_cnt_r + (mis_vld ? {30'h0, mis_inc} : 32'h0000_0000);
      bad_cnt_r <= (wr_take && hit_bcnt) ? 32'h0000_0000 : bad_cnt_r + (bad_vld ? {30'h0, bad_inc} : 32'h0000_0000);
    end
  end

  // Status outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fifo_err               <= 1'b0;
      rx_local_fault            <= 1'b1;
      rx_excess_error_rate_flag <= 1'b0;
      rx_block_lock             <= 4'h0;
      rx_test_err               <= 8'h00;
      rx_test_err_valid         <= 1'b0;
      rx_bad_code               <= 2'h0;
      rx_bad_code_valid         <= 1'b0;
      dec_r                     <= rps_pkg::RPS_DEC_INIT;
      ber_tmr_r                 <= 12'h000;
      ber_cnt_r                 <= 5'h00;
    end else if (ce) begin
      // Held until reset or a buffer restart, since data was already lost.
      // A fault pulse from the cycle before the restart still wins over the clear; rps_ccomp drops a fault in the restart cycle itself.
      rx_fifo_err       <= (cc_clr ? 1'b0 : rx_fifo_err) | cc_pulse;
      dec_r             <= dec_nxt;
      rx_local_fault    <= (dec_nxt == rps_pkg::RPS_DEC_INIT);
      rx_block_lock     <= lock_nxt;
      rx_test_err       <= mis_vld ? {6'h00, mis_inc} : 8'h00;
      rx_test_err_valid <= mis_vld;
      rx_bad_code       <= bad_vld ? bad_inc : 2'h0;
      rx_bad_code_valid <= bad_vld;
      ber_tmr_r         <= ber_end ? 12'h000 : ber_tmr_r + 12'h001;
      ber_cnt_r         <= ber_end ? 5'h00 : ber_sat;
      if (ber_end) begin
        rx_excess_error_rate_flag <= ber_hi;
      end
    end
  end

  // Per-lane header counters behind the lock decision.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        good_r[i] <= 7'h00;
        win_r[i]  <= 7'h00;
        badh_r[i] <= 5'h00;
      end
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        if (lane_hdr_vld[i]) begin
          good_r[i] <= (lane_hdr_ok[i] && !lock_nxt[i]) ? good_r[i] + 7'h01 : 7'h00;
          if (!lock_nxt[i] || win_r[i] == `RPS_LOCK_WIN - 7'h01) begin
            win_r[i]  <= 7'h00;
            badh_r[i] <= 5'h00;
          end else begin
            win_r[i]  <= win_r[i] + 7'h01;
            badh_r[i] <= badh_r[i] + {4'h0, !lane_hdr_ok[i]};
          end
        end
      end
    end
  end

endmodule

//--- dv/rps_top_sva.sv
/*
  Port checker of the receive status block, bound to rps_top.
  Assumes ce is held high by the bench.
*/
`timescale 1ns/1ps
module rps_top_sva (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Datapath.
  input wire logic [3:0]  lane_hdr_vld,
  input wire logic [3:0]  lane_hdr_ok,
  input wire logic        blk_vld,
  input wire logic [1:0]  blk_sh0,
  input wire logic [1:0]  blk_sh1,
  // Status.
  input wire logic        rx_fifo_err,
  input wire logic [3:0]  rx_block_lock,
  input wire logic [7:0]  rx_test_err,
  input wire logic        rx_test_err_valid,
  input wire logic [1:0]  rx_bad_code,
  input wire logic        rx_bad_code_valid
);
  wire clr_w = psel && penable && pwrite && paddr == 8'h00 && pwdata[1];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence two_bad_s;
    blk_vld && blk_sh0[0] == blk_sh0[1] && blk_sh1[0] == blk_sh1[1];
  endsequence
  apb_ready_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  slv_err_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_valid_a: assert property (rx_test_err != 8'h00 |-> rx_test_err_valid && rx_test_err <= 8'h02)
    else $error("mismatch value without valid");
  err_pulse_a: assert property (rx_test_err != 8'h00 && !$past(blk_vld) |=> rx_test_err == 8'h00)
    else $error("mismatch value held");
  err_cause_a: assert property (rx_test_err_valid |-> $past(blk_vld, 2))
    else $error("mismatch valid without blocks");
  bad_valid_a: assert property (blk_vld |-> ##2 rx_bad_code_valid)
    else $error("violation valid missing");
  bad_range_a: assert property (rx_bad_code != 2'h0 |-> rx_bad_code_valid && rx_bad_code != 2'h3)
    else $error("violation value out of range");
  two_bad_a: assert property (two_bad_s |-> ##2 rx_bad_code == 2'h2)
    else $error("two bad headers not counted");
  fifo_sticky_a: assert property (rx_fifo_err && !clr_w && !$past(clr_w) |=> rx_fifo_err)
    else $error("buffer error dropped");
  lock_cause_a: assert property ($rose(rx_block_lock[0]) |-> $past(lane_hdr_vld[0] && lane_hdr_ok[0]))
    else $error("lock without good header");
endmodule
bind rps_top rps_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .lane_hdr_vld, .lane_hdr_ok, .blk_vld, .blk_sh0, .blk_sh1, .rx_fifo_err, .rx_block_lock,
  .rx_test_err, .rx_test_err_valid, .rx_bad_code, .rx_bad_code_valid);

//--- dv/rps_stat_sink.sv
/*
  Statistics consumer model: accumulates increments and notes a buffer error.
  Assumes the status outputs of rps_top on the same clock.
*/
`timescale 1ns/1ps
module rps_stat_sink (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Increments and flags.
  input wire logic [7:0] rx_test_err,
  input wire logic       rx_test_err_valid,
  input wire logic [1:0] rx_bad_code,
  input wire logic       rx_bad_code_valid,
  input wire logic       rx_fifo_err,
  // Totals.
  output int             err_total,
  output int             bad_total,
  output logic           fifo_seen
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_total <= 0;
      bad_total <= 0;
      fifo_seen <= 1'b0;
    end else begin
      if (rx_test_err_valid) err_total <= err_total + int'(rx_test_err);
      if (rx_bad_code_valid) bad_total <= bad_total + int'(rx_bad_code);
      if (rx_fifo_err) fifo_seen <= 1'b1;
    end
  end
endmodule

//--- dv/rps_top_tb_top.sv
/*
  Self-checking bench of rps_top with a block-stream model and an APB master.
  Assumes a 25 MHz clock and ce held high.
*/
`timescale 1ns/1ps
module rps_top_tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, cc_wr_en, cc_rd_en, blk_vld;
  logic        rx_fifo_err, rx_local_fault, rx_excess_error_rate_flag, rx_test_err_valid;
  logic        rx_bad_code_valid, irq, fifo_seen, infr, er;
  logic [7:0]  paddr, blk_type0, blk_type1, rx_test_err, tab [16];
  logic [31:0] pwdata, prdata, seed, rd;
  logic [3:0]  lane_hdr_vld, lane_hdr_ok, rx_block_lock;
  logic [1:0]  blk_sh0, blk_sh1, rx_bad_code;
  int          bad_count, samples_checked, err_total, bad_total, tot_mis, tot_bad;
  logic [11:0] q [$];

  rps_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cc_wr_en, .cc_rd_en, .lane_hdr_vld, .lane_hdr_ok, .blk_vld, .blk_sh0,
    .blk_type0, .blk_sh1, .blk_type1, .rx_fifo_err, .rx_local_fault, .rx_excess_error_rate_flag,
    .rx_block_lock, .rx_test_err, .rx_test_err_valid, .rx_bad_code, .rx_bad_code_valid, .irq);
  rps_stat_sink sink (.pclk, .presetn, .rx_test_err, .rx_test_err_valid, .rx_bad_code,
    .rx_bad_code_valid, .rx_fifo_err, .err_total, .bad_total, .fifo_seen);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Slot model: a start inside a frame or a terminate outside one is an order fault.
  task automatic slot(input int k, input logic m, inout int b, inout int mm);
    if (k == 3 || (k == 1 && infr) || (k == 2 && !infr)) b++;
    if (k == 1) infr = 1'b1;
    if (k == 2 || k == 3) infr = 1'b0;
    mm += int'(m);
  endtask

  task automatic stream(input int n, input logic tst, input logic bad);
    logic [31:0] r;
    logic [1:0]  s0, s1;
    logic [7:0]  t0, t1;
    logic        v;
    int          b, m;
    q = '{12'h000, 12'h000};
    for (int i = 0; i < n + 2; i++) begin
      @(posedge pclk);
      r = xs();
      v = i < n;
      s0 = bad ? {r[0], r[0]} : (r[4] ? 2'h1 : 2'h2);
      s1 = bad ? {r[1], r[1]} : (r[20] ? 2'h1 : 2'h2);
      t0 = r[4] ? r[15:8] : tab[r[3:0]];
      t1 = r[20] ? r[31:24] : tab[r[19:16]];
      b = 0;
      m = 0;
      if (v) begin
        slot(bad ? 3 : r[4] ? 0 : r[3:0] inside {[4:6]} ? 1 : r[3:0] inside {[7:14]} ? 2 : 0,
             !(s0 == 2'h2 && t0 == 8'h1E), b, m);
        slot(bad ? 3 : r[20] ? 0 : r[19:16] inside {[4:6]} ? 1 : r[19:16] inside {[7:14]} ? 2 : 0,
             !(s1 == 2'h2 && t1 == 8'h1E), b, m);
      end
      tot_bad += b;
      tot_mis += tst ? m : 0;
      q.push_back({v, b[1:0], v && tst, tst ? m[7:0] : 8'h00});
      blk_vld <= v;
      blk_sh0 <= s0;
      blk_sh1 <= s1;
      blk_type0 <= t0;
      blk_type1 <= t1;
      #1;
      chk({rx_bad_code_valid, rx_bad_code, rx_test_err_valid, rx_test_err}, q.pop_front());
    end
  endtask

  initial begin
    #1200000;
    bad_count++;
    finish_test();
  end

  initial begin
    tab = '{8'h1E, 8'h2D, 8'h4B, 8'h55, 8'h33, 8'h66, 8'h78, 8'h87, 8'h99, 8'hAA, 8'hB4, 8'hCC, 8'hD2,
            8'hE1, 8'hFF, 8'h1E};
    {presetn, psel, penable, pwrite, cc_wr_en, cc_rd_en, blk_vld, infr} = '0;
    {paddr, pwdata, lane_hdr_vld, lane_hdr_ok, blk_sh0, blk_sh1, blk_type0, blk_type1} = '0;
    ce = 1'b1;
    seed = 32'h9AA9;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({rx_local_fault, rx_fifo_err, rx_excess_error_rate_flag, rx_block_lock, irq}, 32'h80);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    stream(200, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    stream(200, 1'b1, 1'b0);
    apb(1'b1, 8'h0C, 32'h20);
    stream(5, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    #1 chk(irq, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h30, 32'h30);
    apb(1'b1, 8'h10, 32'h30);
    apb(1'b1, 8'h0C, 32'h0);
    stream(3, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    #1 chk(irq, 1'b0);
    @(posedge pclk);
    lane_hdr_vld <= 4'hF;
    lane_hdr_ok <= 4'hF;
    repeat (70) @(posedge pclk);
    #1 chk({rx_local_fault, rx_block_lock}, 32'h0F);
    @(posedge pclk);
    lane_hdr_ok <= 4'hB;
    repeat (20) @(posedge pclk);
    lane_hdr_ok <= 4'hF;
    #1 chk({rx_local_fault, rx_block_lock}, 32'h1B);
    for (int i = 0; i < 3300 && rx_excess_error_rate_flag !== 1'b1; i++) @(posedge pclk);
    chk(rx_excess_error_rate_flag, 1'b1);
    for (int i = 0; i < 6600 && rx_excess_error_rate_flag !== 1'b0; i++) @(posedge pclk);
    chk(rx_excess_error_rate_flag, 1'b0);
    @(posedge pclk);
    cc_wr_en <= 1'b1;
    cc_rd_en <= 1'b1;
    repeat (100) @(posedge pclk);
    #1 chk(rx_fifo_err, 1'b0);
    @(posedge pclk);
    cc_rd_en <= 1'b0;
    repeat (20) @(posedge pclk);
    cc_wr_en <= 1'b0;
    repeat (3) @(posedge pclk);
    #1 chk({rx_fifo_err, fifo_seen}, 2'h3);
    apb(1'b1, 8'h00, 32'h3);
    repeat (3) @(posedge pclk);
    #1 chk(rx_fifo_err, 1'b0);
    chk(err_total, tot_mis);
    chk(bad_total, tot_bad);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, tot_mis);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, tot_bad);
    finish_test();
  end
endmodule
